/* rtl/ojcd_consts.svh */
// Constants for the octal Johnson counter with decoded outputs.
// Assumes inclusion by its bare name from every file that needs a constant.
//
// Summary of operation
// - Four-flop twisted-ring counter walks eight states, dividing the count rate by eight.
// - Eight decoded outputs, each high only in its own state, exactly one high.
// - Decoded outputs come from the ring so they never glitch between states.
// - High clear forces state 0 regardless of count clock; carry and output 0 high.
// - With enable low, each rising count clock edge advances one state.
// - With count clock high, each falling enable edge advances one state.
// - Carry is high in states 0 to 3, low in states 4 to 7.
`ifndef OJCD_CONSTS_SVH
`define OJCD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Counter geometry
// ----------------------------------------------------------------------------
`define OJCD_STAGE_W    4
`define OJCD_STAGE_MSB  3
`define OJCD_STATE_CNT  8
`define OJCD_CNT_W      3

// ----------------------------------------------------------------------------
// Reset and clear values
// ----------------------------------------------------------------------------
`define OJCD_STAGE_RST  4'h0
`define OJCD_DECODE_RST 8'h01
`define OJCD_CARRY_RST  1'h1
`define OJCD_CNT_RST    3'h0
`define OJCD_CNT_ONE    3'h1
`define OJCD_WRAP_STATE 4'h8

// ----------------------------------------------------------------------------
// Pin synchroniser lanes
// ----------------------------------------------------------------------------
`define OJCD_SYNC_W     3
`define OJCD_SYNC_RST   3'h0
`define OJCD_PIN_CLK    0
`define OJCD_PIN_EN     1
`define OJCD_PIN_CLR    2

`endif

/* rtl/ojcd_counter.sv */
// Octal divide-by-eight Johnson counter with eight decoded outputs and carry.
// Assumes count clock, enable and clear arrive as asynchronous pins and that
// each pin level lasts several system clock cycles.
`timescale 1ns/100ps
`include "ojcd_consts.svh"

module ojcd_counter
(
  // System clock and reset
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  // Counter pins
  input  wire logic count_clk_in,
  input  wire logic count_en_n_in,
  input  wire logic clear_in,
  // Decoded state outputs
  output logic      decoded_state_out_0,
  output logic      decoded_state_out_1,
  output logic      decoded_state_out_2,
  output logic      decoded_state_out_3,
  output logic      decoded_state_out_4,
  output logic      decoded_state_out_5,
  output logic      decoded_state_out_6,
  output logic      decoded_state_out_7,
  // Cascade output
  output logic      carry_out
);

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  ojcd_pkg::ojcd_pins_t pins;
  ojcd_pkg::ojcd_pins_t pins_sync;
  logic                 clk_s;
  logic                 en_n_s;
  logic                 clr_s;

  always_comb
  begin
    pins                = `OJCD_SYNC_RST;
    pins[`OJCD_PIN_CLK] = count_clk_in;
    pins[`OJCD_PIN_EN]  = count_en_n_in;
    pins[`OJCD_PIN_CLR] = clear_in;
  end

  ojcd_sync u_sync
  (
    .sys_clk_in    (sys_clk_in),
    .srst_in       (srst_in),
    .pins_in       (pins),
    .pins_sync_out (pins_sync)
  );

  assign clk_s  = pins_sync[`OJCD_PIN_CLK];
  assign en_n_s = pins_sync[`OJCD_PIN_EN];
  assign clr_s  = pins_sync[`OJCD_PIN_CLR];

  // --------------------------------------------------------------------------
  // Count event detection
  // --------------------------------------------------------------------------
  // Both the clock rising under low enable and enable falling under high clock
  // are a rise of the single term clock AND NOT enable.
  logic gate_lvl;
  logic gate_prev_reg;
  logic gate_prev_next;
  logic step;

  assign gate_lvl = clk_s & ~en_n_s;
  assign step     = gate_lvl & ~gate_prev_reg;

  always_comb
  begin
    gate_prev_next = srst_in ? 1'h0 : gate_lvl;
  end

  always_ff @(posedge sys_clk_in)
  begin
    gate_prev_reg <= gate_prev_next;
  end

  // --------------------------------------------------------------------------
  // Johnson ring, decoder and carry
  // --------------------------------------------------------------------------
  ojcd_pkg::ojcd_stage_t  stage_reg;
  ojcd_pkg::ojcd_stage_t  stage_next;
  ojcd_pkg::ojcd_decode_t decode_reg;
  ojcd_pkg::ojcd_decode_t decode_next;
  logic                   carry_reg;
  logic                   carry_next;

  // Each state is named by one adjacent pair of ring bits, so a single bit
  // change between states can never light two outputs at once.
  function automatic ojcd_pkg::ojcd_decode_t decode_f(input ojcd_pkg::ojcd_stage_t q);
    ojcd_pkg::ojcd_decode_t d;
    d    = `OJCD_DECODE_RST;
    d[0] = ~q[3] & ~q[0];
    d[1] =  q[0] & ~q[1];
    d[2] =  q[1] & ~q[2];
    d[3] =  q[2] & ~q[3];
    d[4] =  q[3] &  q[0];
    d[5] = ~q[0] &  q[1];
    d[6] = ~q[1] &  q[2];
    d[7] = ~q[2] &  q[3];
    return d;
  endfunction

  always_comb
  begin
    stage_next = stage_reg;
    if (srst_in || clr_s)
    begin
      stage_next = `OJCD_STAGE_RST;
    end
    else if (step)
    begin
      stage_next = {stage_reg[`OJCD_STAGE_MSB-1:0], ~stage_reg[`OJCD_STAGE_MSB]};
    end
    // Outputs are registered from the next ring value so they move on the
    // same edge as the ring and carry no decode hazard.
    decode_next = decode_f(stage_next);
    carry_next  = ~stage_next[`OJCD_STAGE_MSB];
  end

  always_ff @(posedge sys_clk_in)
  begin
    stage_reg  <= stage_next;
    decode_reg <= decode_next;
    carry_reg  <= carry_next;
  end

  assign decoded_state_out_0 = decode_reg[0];
  assign decoded_state_out_1 = decode_reg[1];
  assign decoded_state_out_2 = decode_reg[2];
  assign decoded_state_out_3 = decode_reg[3];
  assign decoded_state_out_4 = decode_reg[4];
  assign decoded_state_out_5 = decode_reg[5];
  assign decoded_state_out_6 = decode_reg[6];
  assign decoded_state_out_7 = decode_reg[7];
  assign carry_out           = carry_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // Steps taken since the ring last stood in state 0.
  ojcd_pkg::ojcd_cnt_t steps_reg;
  ojcd_pkg::ojcd_cnt_t steps_next;

  always_comb
  begin
    steps_next = steps_reg;
    if (srst_in || clr_s)
    begin
      steps_next = `OJCD_CNT_RST;
    end
    else if (step)
    begin
      steps_next = steps_reg + `OJCD_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    steps_reg <= steps_next;
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking

  default disable iff (srst_in);

  chk_ring_period: assert property
    ((stage_reg == `OJCD_STAGE_RST) == (steps_reg == `OJCD_CNT_RST))
    else $error("Ring does not return to state 0 every eight steps.");

  chk_decode_onehot: assert property ($onehot(decode_reg))
    else $error("Decoded outputs are not one-hot.");

  chk_decode_aligned: assert property
    (decode_reg == decode_f(stage_reg) && carry_reg == ~stage_reg[`OJCD_STAGE_MSB])
    else $error("Decoded outputs lag or lead the ring.");

  chk_clear_forces: assert property
    (clr_s |=> stage_reg == `OJCD_STAGE_RST && carry_out && decoded_state_out_0)
    else $error("Clear did not force state 0 with carry high.");

  chk_clock_step: assert property
    (!en_n_s && $rose(clk_s) && !clr_s |=> stage_reg != $past(stage_reg))
    else $error("Rising count clock with enable low did not advance.");

  chk_enable_step: assert property
    (clk_s && $fell(en_n_s) && !clr_s |=> stage_reg != $past(stage_reg))
    else $error("Falling enable with clock high did not advance.");

  chk_hold_idle: assert property (!step && !clr_s |=> $stable(stage_reg))
    else $error("Ring moved without a count event.");

  chk_carry_half: assert property (carry_out == (|decode_reg[3:0]))
    else $error("Carry not high exactly in states 0 to 3.");

  chk_ring_order: assert property
    (step && !clr_s |=> stage_reg == {$past(stage_reg[2:0]), ~$past(stage_reg[3])})
    else $error("Ring stepped out of order.");

  chk_ring_wrap: assert property
    (stage_reg == `OJCD_WRAP_STATE && step && !clr_s |=>
     decoded_state_out_0 && $rose(carry_out))
    else $error("Last state did not wrap to state 0.");

  cov_wrap: cover property (stage_reg == `OJCD_WRAP_STATE && step && !clr_s);
  cov_clear: cover property (clr_s && stage_reg != `OJCD_STAGE_RST);
  cov_enable_path: cover property (clk_s && $fell(en_n_s) && !clr_s);
  cov_inhibit: cover property ($rose(clk_s) && en_n_s);

endmodule

/* rtl/ojcd_pkg.sv */
// Types shared by the octal Johnson counter design.
// Assumes ojcd_consts.svh is on the include path.
`include "ojcd_consts.svh"

package ojcd_pkg;
  typedef logic [`OJCD_STAGE_W-1:0]   ojcd_stage_t;
  typedef logic [`OJCD_STATE_CNT-1:0] ojcd_decode_t;
  typedef logic [`OJCD_SYNC_W-1:0]    ojcd_pins_t;
  typedef logic [`OJCD_CNT_W-1:0]     ojcd_cnt_t;
endpackage

/* rtl/ojcd_sync.sv */
// Two-flop synchronisers for the asynchronous counter pins.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "ojcd_consts.svh"

module ojcd_sync
(
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  // Pins and their synchronised copies
  input  wire ojcd_pkg::ojcd_pins_t pins_in,
  output ojcd_pkg::ojcd_pins_t      pins_sync_out
);

  ojcd_pkg::ojcd_pins_t meta_reg;
  ojcd_pkg::ojcd_pins_t meta_next;
  ojcd_pkg::ojcd_pins_t sync_reg;
  ojcd_pkg::ojcd_pins_t sync_next;

  // --------------------------------------------------------------------------
  // One lane per pin; the first flop feeds only the second.
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `OJCD_SYNC_W; g++)
    begin : g_lane
      always_comb
      begin
        meta_next[g] = srst_in ? 1'h0 : pins_in[g];
        sync_next[g] = srst_in ? 1'h0 : meta_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in)
  begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign pins_sync_out = sync_reg;

endmodule

/* verif/ojcd_src_model.sv */
// Model of the clock and enable source that drives the counter pins.
// Assumes the bench calls its tasks from a process that runs on the system clock.
`timescale 1ns/100ps

module ojcd_src_model
(
  // System clock
  input  wire logic sys_clk_in,
  // Counter pins
  output logic      count_clk_out,
  output logic      count_en_n_out
);
  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  // Each level is held six cycles so the synchronisers see it and settle.
  initial
  begin
    count_clk_out  = 1'b0;
    count_en_n_out = 1'b1;
  end

  task automatic set_clk(input logic v);
    @(posedge sys_clk_in);
    count_clk_out <= v;
    repeat (6) @(posedge sys_clk_in);
  endtask

  task automatic set_en_n(input logic v);
    @(posedge sys_clk_in);
    count_en_n_out <= v;
    repeat (6) @(posedge sys_clk_in);
  endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the octal Johnson counter.
// Assumes the source model drives count clock and enable; the bench drives clear.
`timescale 1ns/100ps

module tb_top;
  logic       sys_clk_in;
  logic       srst_in;
  logic       clear_in;
  wire logic  count_clk_in;
  wire logic  count_en_n_in;
  wire logic  dec_0;
  wire logic  dec_1;
  wire logic  dec_2;
  wire logic  dec_3;
  wire logic  dec_4;
  wire logic  dec_5;
  wire logic  dec_6;
  wire logic  dec_7;
  wire logic  carry;
  logic [7:0] dec;
  int         mismatches = 0;
  int         n_checks   = 0;
  int         cycles     = 0;
  int         exp_state  = 0;

  always #4 sys_clk_in = ~sys_clk_in;

  ojcd_src_model u_src
  (
    .sys_clk_in     (sys_clk_in),
    .count_clk_out  (count_clk_in),
    .count_en_n_out (count_en_n_in)
  );

  ojcd_counter u_dut
  (
    .sys_clk_in          (sys_clk_in),
    .srst_in             (srst_in),
    .count_clk_in        (count_clk_in),
    .count_en_n_in       (count_en_n_in),
    .clear_in            (clear_in),
    .decoded_state_out_0 (dec_0),
    .decoded_state_out_1 (dec_1),
    .decoded_state_out_2 (dec_2),
    .decoded_state_out_3 (dec_3),
    .decoded_state_out_4 (dec_4),
    .decoded_state_out_5 (dec_5),
    .decoded_state_out_6 (dec_6),
    .decoded_state_out_7 (dec_7),
    .carry_out           (carry)
  );

  assign dec = {dec_7, dec_6, dec_5, dec_4, dec_3, dec_2, dec_1, dec_0};

  // --------------------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    n_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  function automatic logic [8:0] want();
    return {exp_state < 4, 8'h01 << exp_state};
  endfunction

  task automatic test_done();
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      test_done();
    end
  end

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Ten steps cover the full ring and the wrap back to state 0.
  task automatic t_clock_count();
    u_src.set_en_n(1'b0);
    for (int i = 0; i < 10; i++)
    begin
      u_src.set_clk(1'b1);
      exp_state = (exp_state + 1) % 8;
      check({carry, dec}, want());
      u_src.set_clk(1'b0);
      check({carry, dec}, want());
    end
  endtask

  // A clock rise while inhibited must not count; enable falls then step it.
  task automatic t_enable_step();
    for (int i = 0; i < 5; i++)
    begin
      u_src.set_en_n(1'b1);
      if (i == 0)
        u_src.set_clk(1'b1);
      check({carry, dec}, want());
      u_src.set_en_n(1'b0);
      exp_state = (exp_state + 1) % 8;
      check({carry, dec}, want());
    end
    u_src.set_clk(1'b0);
    check({carry, dec}, want());
  endtask

  // Clear in mid-count returns to state 0 and holds it against count edges.
  task automatic t_clear();
    @(posedge sys_clk_in);
    clear_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    exp_state = 0;
    check({carry, dec}, want());
    u_src.set_clk(1'b1);
    u_src.set_clk(1'b0);
    check({carry, dec}, want());
    @(posedge sys_clk_in);
    clear_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    u_src.set_clk(1'b1);
    exp_state = 1;
    check({carry, dec}, want());
    u_src.set_clk(1'b0);
  endtask

  initial
  begin
    sys_clk_in = 1'b0;
    srst_in    = 1'b1;
    clear_in   = 1'b0;
    repeat (16) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    check({carry, dec}, want());
    t_clock_count();
    t_enable_step();
    t_clear();
    test_done();
  end
endmodule
